/* design/sbb_pkg.sv */
package sbb_pkg;
	// Register offsets on the configuration register port
	localparam logic [7:0] SBB_OFS_DATA = 8'hB0;
	localparam logic [7:0] SBB_OFS_WORD = 8'hB1;
	localparam logic [7:0] SBB_OFS_TARGET = 8'hB2;
	localparam logic [7:0] SBB_OFS_CTRL = 8'hB3;

	// Reset values
	localparam logic [7:0] SBB_RST_DATA = 8'h00;
	localparam logic [7:0] SBB_RST_WORD = 8'h00;
	localparam logic [7:0] SBB_RST_TARGET = 8'h00;
	localparam logic SBB_RST_CTRL_BIT = 1'b0;

	// Field positions
	localparam int SBB_TGT_DIR_BIT = 0;
	localparam int SBB_CTRL_ADDRSEL_BIT = 7;
	localparam int SBB_CTRL_BUSY_BIT = 5;
	localparam int SBB_CTRL_TEST_BIT = 2;
	localparam int SBB_CTRL_FAULT_BIT = 1;

	// Serial clock timing: one bit is four quarter periods
	localparam int SBB_CLK_KHZ = 100000;
	localparam int SBB_SCL_NORMAL_KHZ = 60;
	localparam int SBB_SCL_TEST_KHZ = 4000;
	localparam logic [11:0] SBB_QTR_NORMAL =
		12'(SBB_CLK_KHZ / (4 * SBB_SCL_NORMAL_KHZ));
	localparam logic [11:0] SBB_QTR_TEST =
		12'(SBB_CLK_KHZ / (4 * SBB_SCL_TEST_KHZ));

	typedef enum logic [2:0] {
		stIdle,
		stStart,
		stAddr,
		stWord,
		stRestart,
		stAddrRd,
		stData,
		stStop
	} sbb_state_t;
endpackage : sbb_pkg

/* design/sbb_byte_access.sv */
// Operation
// - A read cycle leaves the received byte in the data register, valid once the busy flag clears.
// - The word-address register holds the word address, loaded by software before the launch.
// - A software write to the target-address register while no cycle runs starts one serial cycle with it; writes while busy are ignored.
// - The 7-bit slave address is target-address bits 7:1 and resets to zero.
// - Target-address bit 0 selects write (0, default) or read (1) of a single byte.
// - Data, word-address and target-address registers clear on link, global and power-on reset.
// - The transfer-in-progress flag is high while a software cycle runs and drops when it ends.
// - With addressing select 0 both slave and word address are sent, with 1 only the slave address.
// - A sticky transfer-fault flag is set when a slave does not acknowledge a sent byte and cleared by reading it.
`timescale 1ns/10ps
module sbb_byte_access
	import sbb_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic fundamentalResetN,
	input wire logic globalResetInputN,
	input wire logic [7:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);
	typedef struct packed {
		sbb_state_t st;
		logic [7:0] data;
		logic [7:0] word;
		logic [7:0] tgt;
		logic addrSel;
		logic testMode;
		logic fault;
		logic busy;
		logic [7:0] shift;
		logic [3:0] bitCnt;
		logic [1:0] qtr;
		logic [11:0] div;
		logic sclLow;
		logic sdaLow;
		logic [1:0] sdaSync;
		logic [1:0] sclSync;
		logic [7:0] rdata;
	} sbb_regs_t;

	logic [1:0] rstSync_q;
	sbb_regs_t r_q;
	sbb_regs_t r_d;
	logic rawRstN;
	logic [11:0] qtrMax;
	logic step;
	logic rxByte;
	logic faultSet;
	logic launch;

	// All three reset sources clear the same registers
	assign rawRstN = rst_n & fundamentalResetN & globalResetInputN;

	always_ff @(posedge clock or negedge rawRstN)
	begin
		if (!rawRstN)
			rstSync_q <= 2'h0;
		else
			rstSync_q <= {rstSync_q[0], 1'b1};
	end

	assign qtrMax = r_q.testMode ? SBB_QTR_TEST : SBB_QTR_NORMAL;
	assign launch = regWr && regAddr == SBB_OFS_TARGET && !r_q.busy;
	// A slave holding SCL low stretches the high quarter
	assign step = r_q.busy && r_q.div == 12'h000
		&& (r_q.sclLow || r_q.sclSync[1]);
	assign rxByte = r_q.st == stData && r_q.tgt[SBB_TGT_DIR_BIT];

	always_comb
	begin
		r_d = r_q;
		faultSet = 1'b0;
		r_d.sdaSync = {r_q.sdaSync[0], sdaIn};
		r_d.sclSync = {r_q.sclSync[0], sclIn};
		if (r_q.busy && r_q.div != 12'h000)
			r_d.div = r_q.div - 12'h001;
		else
			r_d.div = qtrMax - 12'h001;
		if (step)
		begin
			r_d.qtr = r_q.qtr + 2'h1;
			case (r_q.st)
				stStart, stRestart:
				begin
					case (r_q.qtr)
						2'h0:
						begin
							r_d.sclLow = r_q.st == stRestart;
							r_d.sdaLow = 1'b0;
						end
						2'h1: r_d.sclLow = 1'b0;
						2'h2: r_d.sdaLow = 1'b1;
						default:
						begin
							r_d.sclLow = 1'b1;
							r_d.bitCnt = 4'h0;
							if (r_q.st == stRestart)
							begin
								r_d.st = stAddrRd;
								r_d.shift = {r_q.tgt[7:1], 1'b1};
							end
							else
							begin
								r_d.st = stAddr;
								// Direction goes out first only when no word
								// address precedes it
								r_d.shift = r_q.addrSel ? r_q.tgt
									: {r_q.tgt[7:1], 1'b0};
							end
						end
					endcase
				end
				stAddr, stWord, stAddrRd, stData:
				begin
					case (r_q.qtr)
						2'h0:
						begin
							r_d.sclLow = 1'b1;
							r_d.sdaLow = r_q.bitCnt < 4'h8 && !rxByte
								&& !r_q.shift[7];
						end
						2'h1: r_d.sclLow = r_q.sclLow;
						2'h2: r_d.sclLow = 1'b0;
						default:
						begin
							r_d.bitCnt = r_q.bitCnt + 4'h1;
							if (r_q.bitCnt < 4'h8)
								r_d.shift = {r_q.shift[6:0],
									rxByte & r_q.sdaSync[1]};
							else
							begin
								r_d.bitCnt = 4'h0;
								if (!rxByte && r_q.sdaSync[1])
								begin
									faultSet = 1'b1;
									r_d.st = stStop;
								end
								else if (r_q.st == stAddr)
								begin
									if (!r_q.addrSel)
									begin
										r_d.st = stWord;
										r_d.shift = r_q.word;
									end
									else
									begin
										r_d.st = stData;
										r_d.shift = r_q.data;
									end
								end
								else if (r_q.st == stWord)
								begin
									r_d.st = r_q.tgt[SBB_TGT_DIR_BIT]
										? stRestart : stData;
									r_d.shift = r_q.data;
								end
								else if (r_q.st == stAddrRd)
									r_d.st = stData;
								else
								begin
									// Master ends a read with a NACK
									if (rxByte)
										r_d.data = r_q.shift;
									r_d.st = stStop;
								end
							end
						end
					endcase
				end
				stStop:
				begin
					case (r_q.qtr)
						2'h0:
						begin
							r_d.sclLow = 1'b1;
							r_d.sdaLow = 1'b1;
						end
						2'h1: r_d.sclLow = 1'b0;
						2'h2: r_d.sdaLow = 1'b0;
						default:
						begin
							r_d.busy = 1'b0;
							r_d.st = stIdle;
						end
					endcase
				end
				default: r_d.st = stIdle;
			endcase
		end
		// Writes during a cycle would corrupt the bytes in flight
		if (regWr && !r_q.busy)
		begin
			if (regAddr == SBB_OFS_DATA)
				r_d.data = regWdata;
			else if (regAddr == SBB_OFS_WORD)
				r_d.word = regWdata;
			else if (regAddr == SBB_OFS_TARGET)
			begin
				r_d.tgt = regWdata;
				r_d.busy = 1'b1;
				r_d.st = stStart;
				r_d.qtr = 2'h0;
				r_d.div = qtrMax - 12'h001;
			end
		end
		if (regWr && regAddr == SBB_OFS_CTRL)
		begin
			r_d.addrSel = regWdata[SBB_CTRL_ADDRSEL_BIT];
			r_d.testMode = regWdata[SBB_CTRL_TEST_BIT];
		end
		if (regRd)
		begin
			r_d.rdata = 8'h00;
			if (regAddr == SBB_OFS_DATA)
				r_d.rdata = r_q.data;
			else if (regAddr == SBB_OFS_WORD)
				r_d.rdata = r_q.word;
			else if (regAddr == SBB_OFS_TARGET)
				r_d.rdata = r_q.tgt;
			else if (regAddr == SBB_OFS_CTRL)
			begin
				r_d.rdata[SBB_CTRL_ADDRSEL_BIT] = r_q.addrSel;
				r_d.rdata[SBB_CTRL_BUSY_BIT] = r_q.busy;
				r_d.rdata[SBB_CTRL_TEST_BIT] = r_q.testMode;
				r_d.rdata[SBB_CTRL_FAULT_BIT] = r_q.fault;
				r_d.fault = 1'b0;
			end
		end
		// A fault in the same cycle as the clearing read survives
		if (faultSet)
			r_d.fault = 1'b1;
	end

	always_ff @(posedge clock or negedge rstSync_q[1])
	begin
		if (!rstSync_q[1])
		begin
			r_q <= '0;
			r_q.st <= stIdle;
			r_q.data <= SBB_RST_DATA;
			r_q.word <= SBB_RST_WORD;
			r_q.tgt <= SBB_RST_TARGET;
			r_q.addrSel <= SBB_RST_CTRL_BIT;
			r_q.testMode <= SBB_RST_CTRL_BIT;
			r_q.fault <= SBB_RST_CTRL_BIT;
			r_q.sdaSync <= 2'h3;
			r_q.sclSync <= 2'h3;
		end
		else
			r_q <= r_d;
	end

	assign regRdata = r_q.rdata;
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = r_q.sclLow;
	assign sdaOe = r_q.sdaLow;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstSync_q[1]);

	sequence launchSeq;
		launch;
	endsequence
	sequence startSeq;
		r_q.st == stStart && !r_q.sdaLow ##1 r_q.busy [*2];
	endsequence

	a_launch_busy: assert property (launchSeq |=> startSeq)
		else $error("launch did not start a busy cycle");
	a_target_store: assert property (launchSeq |=>
		r_q.tgt == $past(regWdata))
		else $error("target address not stored on launch");
	a_busy_end: assert property ($fell(r_q.busy) |->
		$past(r_q.st) == stStop && r_q.st == stIdle)
		else $error("busy dropped outside stop");
	a_word_skip: assert property (r_q.st == stAddr && r_d.st == stWord
		|-> !r_q.addrSel)
		else $error("word address sent with addressing select set");
	a_fault_hold: assert property (r_q.fault && !(regRd
		&& regAddr == SBB_OFS_CTRL) |=> r_q.fault)
		else $error("fault flag lost without a read");
	// The clearing read still reports the flag as it stood before
	a_fault_clear: assert property (regRd && regAddr == SBB_OFS_CTRL
		&& !faultSet |=> !r_q.fault
		&& r_q.rdata[SBB_CTRL_FAULT_BIT] == $past(r_q.fault))
		else $error("fault flag not cleared by read");
	a_read_capture: assert property (rxByte && step && r_q.qtr == 2'h3
		&& r_q.bitCnt == 4'h8 |=> r_q.data == $past(r_q.shift))
		else $error("read byte not stored in data register");
	a_reset_clear: assert property ($rose(rstSync_q[1]) |->
		r_q.data == 8'h00 && r_q.word == 8'h00 && r_q.tgt == 8'h00)
		else $error("registers not cleared by reset");
	a_start_cond: assert property (r_q.st == stStart && step
		&& r_q.qtr == 2'h2 |=> sdaOe && !sclOe)
		else $error("start condition malformed");
	a_dir_first: assert property (r_q.st == stStart && step
		&& r_q.qtr == 2'h3 && r_q.addrSel |=> r_q.shift[0]
		== r_q.tgt[SBB_TGT_DIR_BIT])
		else $error("direction bit not sent with address");
endmodule : sbb_byte_access

/* test/sbb_slave_model.sv */
`timescale 1ns/10ps
module sbb_slave_model #(parameter logic [6:0] DEV = 7'h50)
(
	input wire logic scl,
	input wire logic sda,
	output logic sdaOe,
	output logic [7:0] ptr
);
	logic [7:0] mem [256];
	logic [7:0] sh;
	logic act = 0;
	logic rd;
	logic sel;
	int cnt;
	int nb;
	initial sdaOe = 0;
	initial ptr = 8'h00;
	always @(negedge sda)
		if (scl)
		begin
			act = 1;
			cnt = 0;
			nb = 0;
		end
	always @(posedge sda)
		if (scl)
		begin
			act = 0;
			sdaOe = 0;
		end
	always @(posedge scl)
		if (act && cnt < 8)
		begin
			sh = {sh[6:0], sda};
			cnt++;
		end
		else if (act && cnt == 9 && rd && nb > 0 && sda)
			act = 0;
	always @(negedge scl)
		if (act && cnt == 8)
		begin
			if (nb == 0)
			begin
				sel = sh[7:1] == DEV;
				rd = sh[0];
			end
			else if (!rd && nb == 1)
				ptr = sh;
			else if (!rd)
				mem[ptr] = sh;
			// Foreign addresses stay unanswered so the master sees a NACK
			sdaOe = sel && !(rd && nb > 0);
			cnt = 9;
		end
		else if (act)
		begin
			if (cnt == 9)
			begin
				cnt = 0;
				nb++;
			end
			sdaOe = rd && sel && nb > 0 && !mem[ptr][7 - cnt];
		end
endmodule : sbb_slave_model

/* test/serial_bus_byte_access_regs_tb_top.sv */
`timescale 1ns/10ps
module serial_bus_byte_access_regs_tb_top;
	import sbb_pkg::*;
	logic clock = 0;
	logic [2:0] rstV = 3'b110;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 0;
	logic regRd = 0;
	logic [7:0] regRdata;
	logic [7:0] v;
	logic [7:0] seen;
	logic [7:0] ptr;
	logic sclOe;
	logic sdaOe;
	logic slvOe;
	int fails = 0;
	int checks = 0;
	wire scl = !sclOe;
	// Delay keeps data edges apart from the clock edge of the same flop
	wire #1 sda = !(sdaOe || slvOe);
	always #5 clock = !clock;
	sbb_byte_access uut (.clock, .rst_n(rstV[0]),
		.fundamentalResetN(rstV[2]), .globalResetInputN(rstV[1]),
		.regAddr, .regWr, .regRd, .regWdata, .regRdata, .sclIn(scl),
		.sclOut(), .sclOe, .sdaIn(sda), .sdaOut(), .sdaOe);
	sbb_slave_model model (.scl, .sda, .sdaOe(slvOe), .ptr);
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regWdata = d;
		regWr = 1;
		@(negedge clock);
		regWr = 0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regRd = 1;
		@(negedge clock);
		regRd = 0;
		d = regRdata;
	endtask : rd
	task give_verdict;
		$display("fails %0d checks %0d", fails, checks);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// Status reads clear the fault, so every read is folded into seen
	task waitIdle;
		int i;
		seen = 8'h00;
		for (i = 0; i < 2000; i++)
		begin
			rd(SBB_OFS_CTRL, v);
			seen = seen | v;
			if (v[SBB_CTRL_BUSY_BIT] !== 1'b1)
				break;
		end
		if (i == 2000)
		begin
			fails++;
			give_verdict();
		end
	endtask : waitIdle
	task resetValues(input logic [7:0] ctrl);
		for (int i = 0; i < 4; i++)
		begin
			rd(SBB_OFS_DATA + 8'(i), v);
			chk(v, i == 3 ? ctrl : 8'h00);
		end
	endtask : resetValues
	task writeCycle;
		wr(SBB_OFS_CTRL, 8'h04);
		wr(SBB_OFS_DATA, 8'hA5);
		wr(SBB_OFS_WORD, 8'h3C);
		wr(SBB_OFS_TARGET, 8'hA0);
		wr(SBB_OFS_DATA, 8'h77);
		waitIdle();
		chk(seen, 8'h24);
		chk(model.mem[8'h3C], 8'hA5);
		rd(SBB_OFS_TARGET, v);
		chk(v, 8'hA0);
	endtask : writeCycle
	task readCycle;
		wr(SBB_OFS_DATA, 8'h00);
		wr(SBB_OFS_TARGET, 8'hA1);
		waitIdle();
		rd(SBB_OFS_DATA, v);
		chk(v, 8'hA5);
		chk(ptr, 8'h3C);
	endtask : readCycle
	task faultCycle;
		wr(SBB_OFS_TARGET, 8'h66);
		waitIdle();
		chk(seen, 8'h26);
		rd(SBB_OFS_CTRL, v);
		chk(v, 8'h04);
	endtask : faultCycle
	task addrOnly;
		wr(SBB_OFS_CTRL, 8'h84);
		wr(SBB_OFS_DATA, 8'h5A);
		wr(SBB_OFS_TARGET, 8'hA0);
		waitIdle();
		chk(seen, 8'hA4);
		chk(ptr, 8'h5A);
	endtask : addrOnly
	task midResets;
		for (int k = 0; k < 3; k++)
		begin
			wr(SBB_OFS_DATA, 8'h11);
			wr(SBB_OFS_WORD, 8'h22);
			wr(SBB_OFS_TARGET, 8'h02);
			rstV[k] = 0;
			repeat (2) @(negedge clock);
			rstV[k] = 1;
			repeat (4) @(negedge clock);
			resetValues(8'h00);
		end
	endtask : midResets
	initial
	begin
		repeat (10) @(negedge clock);
		rstV[0] = 1;
		repeat (4) @(negedge clock);
		resetValues(8'h00);
		writeCycle();
		readCycle();
		faultCycle();
		addrOnly();
		midResets();
		give_verdict();
	end
endmodule : serial_bus_byte_access_regs_tb_top
